// ### island_io_model.sv
// Model of the island I/O modules that feed the comparator's pin inputs.
// Assumes the bench sets the wanted levels; the model launches them off the clock.
`timescale 1ns/1ps

module island_io_model (
    input  wire logic        i_clk_sys,
    input  wire logic [15:0] i_word,
    input  wire logic        i_level,
    output logic      [15:0] o_island_word,
    output logic             o_enable_pin
);
    // ======================================================================
    // Module outputs
    // unsigned words only
    // The analog module here only ever reports unsigned magnitudes.
    always_ff @(posedge i_clk_sys) begin
        o_island_word <= i_word;
        o_enable_pin  <= i_level;
    end
endmodule

// ### outside_window_compare.sv
// Outside-the-window unsigned compare with hysteresis and a plain register port.
// Assumes one 10 MHz clock, a synchronous active-high reset, and a register
// master that never issues read and write strobes together.
//
// How it works
// - Zero delta: result 1 below lower or at or above upper, 0 between.
// - Rising from below, result stays 1 until above lower plus delta.
// - Rising inside, result goes 1 on reaching upper plus delta.
// - Falling from above, result stays 1 until down to upper minus delta.
// - Falling inside, result stays 0 until below lower minus delta.
// - Inside a hysteresis band the previous result is kept.
// - The operand is an unsigned 16-bit magnitude; bit 15 is value.
// - Operand may come from the virtual module analog word.
// - As a second stage, operand is the first stage output word.
// - Nested with a counter, operand is the counter count word.
// - As a first stage, result goes to the action module, no channel.
// - A dedicated output channel follows only the result unless first stage is set; then it follows fieldbus data.
// - The fieldbus-written channel bit stays writable and usable as an input.
// - When disabled the result freezes while inputs are still sampled.
// - When enabled again the latest inputs are acted on at once.
`timescale 1ns/1ps
`include "window_cmp_consts.svh"

module outside_window_compare #(
    parameter int ADDR_W = 8
) (
    input  wire logic                i_clk_sys,
    input  wire logic                i_sys_rst,
    input  wire logic [ADDR_W-1:0]   i_addr,
    input  wire logic [31:0]         i_wr_data,
    input  wire logic                i_wr_stb,
    input  wire logic                i_rd_stb,
    input  wire logic [`WORD_W-1:0]  i_island_word,
    input  wire logic                i_enable_pin,
    input  wire logic [`WORD_W-1:0]  i_stage1_word,
    input  wire logic [`WORD_W-1:0]  i_count_word,
    output logic      [31:0]         o_rd_data,
    output logic                     o_result,
    output logic                     o_channel_out,
    output logic                     o_action_bit
);

    // ======================================================================
    // Address decode
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [7:0]        ofs);
        reg_hit = (addr == ADDR_W'(ofs));
    endfunction

    window_cmp_pkg::ctrl_t        ctrl_q;
    window_cmp_pkg::cfg_t         cfg_q;
    logic [`WORD_W-1:0]           vm_word_q;
    logic [`FB_W-1:0]             fb_image_q;
    logic [`WORD_W-1:0]           operand_q;
    logic [`WORD_W-1:0]           operand_d;
    window_cmp_pkg::zone_t        zone_q;
    window_cmp_pkg::zone_t        zone_d;
    logic                         result_d;
    logic                         enabled;
    logic                         go_high;
    logic                         go_low;
    logic                         cfg_invalid;
    logic                         enable_pin_s;
    logic [`WORD_W-1:0]           island_word_s;
    logic [`STATUS_W-1:0]         status;
    logic [31:0]                  rd_mux;

    // ======================================================================
    // Pin synchronisers
    two_flop_sync #(
        .W (1)
    ) u_sync_enable (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_enable_pin),
        .o_sync    (enable_pin_s)
    );

    two_flop_sync #(
        .W (`WORD_W)
    ) u_sync_island (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_island_word),
        .o_sync    (island_word_s)
    );

    // ======================================================================
    // Register writes
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            ctrl_q <= window_cmp_pkg::ctrl_t'(`RST_CTRL);
        end else if (i_wr_stb && reg_hit(i_addr, `OFS_CTRL)) begin
            ctrl_q <= window_cmp_pkg::ctrl_t'(i_wr_data[`CTRL_W-1:0]);
        end
    end

    // Threshold and delta validity is left to software; the logic never clamps.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            cfg_q.lower_threshold <= `RST_LOWER_TH;
            cfg_q.upper_threshold <= `RST_UPPER_TH;
            cfg_q.delta           <= `RST_DELTA;
        end else if (i_wr_stb) begin
            if (reg_hit(i_addr, `OFS_LOWER_TH)) begin
                cfg_q.lower_threshold <= i_wr_data[`WORD_W-1:0];
            end
            if (reg_hit(i_addr, `OFS_UPPER_TH)) begin
                cfg_q.upper_threshold <= i_wr_data[`WORD_W-1:0];
            end
            if (reg_hit(i_addr, `OFS_DELTA)) begin
                cfg_q.delta <= i_wr_data[`WORD_W-1:0];
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            vm_word_q <= `RST_WORD;
        end else if (i_wr_stb && reg_hit(i_addr, `OFS_VM_WORD)) begin
            vm_word_q <= i_wr_data[`WORD_W-1:0];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            fb_image_q <= `RST_FB;
        end else if (i_wr_stb && reg_hit(i_addr, `OFS_FB_IMAGE)) begin
            fb_image_q <= i_wr_data[`FB_W-1:0];
        end
    end

    // ======================================================================
    // Operand selection and enable
    always_comb begin
        case (ctrl_q.src)
            window_cmp_pkg::SRC_VIRTUAL: operand_d = vm_word_q;
            window_cmp_pkg::SRC_STAGE1:  operand_d = i_stage1_word;
            window_cmp_pkg::SRC_COUNTER: operand_d = i_count_word;
            default:                     operand_d = island_word_s;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            operand_q <= `RST_WORD;
        end else begin
            operand_q <= operand_d;
        end
    end

    always_comb begin
        case (ctrl_q.en_mode)
            window_cmp_pkg::EN_ALWAYS_ON: enabled = 1'b1;
            window_cmp_pkg::EN_PIN:       enabled = enable_pin_s;
            window_cmp_pkg::EN_FIELDBUS:  enabled = fb_image_q[`FB_ECHO_BIT];
            default:                      enabled = 1'b0;
        endcase
    end

    // ======================================================================
    // Window decision
    window_judge u_judge (
        .i_operand (operand_q),
        .i_cfg     (cfg_q),
        .o_go_high (go_high),
        .o_go_low  (go_low),
        .o_zone    (zone_d)
    );

    // Outside wins when both hold, which happens only at the upper threshold with zero delta.
    // Hold or act.
    always_comb begin
        result_d = o_result;
        if (enabled) begin
            if (go_high) begin
                result_d = 1'b1;
            end else if (go_low) begin
                result_d = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_result <= 1'b0;
            zone_q   <= window_cmp_pkg::ZONE_INSIDE;
        end else begin
            o_result <= result_d;
            zone_q   <= zone_d;
        end
    end

    // ======================================================================
    // Output routing
    // Dedicated channel ignores fieldbus unless first stage is set.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_channel_out <= 1'b0;
        end else if (ctrl_q.chan_dedicated && !ctrl_q.first_stage) begin
            o_channel_out <= result_d;
        end else begin
            o_channel_out <= fb_image_q[`FB_CHAN_BIT];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_action_bit <= 1'b0;
        end else begin
            o_action_bit <= ctrl_q.first_stage & result_d;
        end
    end

    // ======================================================================
    // Status and read port
    // The flag only reports a bad setup; software owns the correction.
    always_comb begin
        cfg_invalid = ({2'b00, cfg_q.upper_threshold}
                       <= ({2'b00, cfg_q.lower_threshold} + {1'b0, cfg_q.delta, 1'b0}));
        status = {cfg_invalid, enabled, zone_q, o_result};
    end

    always_comb begin
        rd_mux = `RST_RD_DATA;
        if (reg_hit(i_addr, `OFS_CTRL)) begin
            rd_mux[`CTRL_W-1:0] = ctrl_q;
        end else if (reg_hit(i_addr, `OFS_LOWER_TH)) begin
            rd_mux[`WORD_W-1:0] = cfg_q.lower_threshold;
        end else if (reg_hit(i_addr, `OFS_UPPER_TH)) begin
            rd_mux[`WORD_W-1:0] = cfg_q.upper_threshold;
        end else if (reg_hit(i_addr, `OFS_DELTA)) begin
            rd_mux[`WORD_W-1:0] = cfg_q.delta;
        end else if (reg_hit(i_addr, `OFS_VM_WORD)) begin
            rd_mux[`WORD_W-1:0] = vm_word_q;
        end else if (reg_hit(i_addr, `OFS_FB_IMAGE)) begin
            rd_mux[`FB_W-1:0] = fb_image_q;
        end else if (reg_hit(i_addr, `OFS_STATUS)) begin
            rd_mux[`STATUS_W-1:0] = status;
        end else if (reg_hit(i_addr, `OFS_OPERAND)) begin
            rd_mux[`WORD_W-1:0] = operand_q;
        end
    end

    // Read data stand for exactly one cycle, then fall back to zero.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_rd_data <= `RST_RD_DATA;
        end else if (i_rd_stb) begin
            o_rd_data <= rd_mux;
        end else begin
            o_rd_data <= `RST_RD_DATA;
        end
    end

    // ======================================================================
    // Checks
    logic [`WORD_W:0] chk_op_d;
    logic [`WORD_W:0] chk_hi_d;
    logic [`WORD_W:0] chk_lo_d;

    always_comb begin
        chk_op_d = {1'b0, operand_q} + {1'b0, cfg_q.delta};
        chk_hi_d = {1'b0, cfg_q.upper_threshold} + {1'b0, cfg_q.delta};
        chk_lo_d = {1'b0, cfg_q.lower_threshold} + {1'b0, cfg_q.delta};
    end

    property p_zero_delta_outside;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (enabled && cfg_q.delta == 16'h0000
         && (operand_q < cfg_q.lower_threshold || operand_q > cfg_q.upper_threshold))
        |=> o_result;
    endproperty
    a_zero_delta_outside: assert property (p_zero_delta_outside)
        else $error("result not one outside the window");

    property p_rise_from_low;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (enabled && o_result && {1'b0, operand_q} > chk_lo_d
         && chk_op_d <= {1'b0, cfg_q.upper_threshold}
         && {1'b0, operand_q} < chk_hi_d)
        |=> !o_result;
    endproperty
    a_rise_from_low: assert property (p_rise_from_low)
        else $error("result did not drop above lower plus delta");

    property p_reach_high;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (enabled && !o_result && {1'b0, operand_q} >= chk_hi_d) |=> o_result;
    endproperty
    a_reach_high: assert property (p_reach_high)
        else $error("result did not rise at upper plus delta");

    property p_fall_from_high;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (enabled && o_result && chk_op_d <= {1'b0, cfg_q.upper_threshold}
         && {1'b0, operand_q} > chk_lo_d && {1'b0, operand_q} < chk_hi_d)
        |=> !o_result;
    endproperty
    a_fall_from_high: assert property (p_fall_from_high)
        else $error("result did not drop at upper minus delta");

    property p_below_low;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (enabled && chk_op_d < {1'b0, cfg_q.lower_threshold}) |=> o_result;
    endproperty
    a_below_low: assert property (p_below_low)
        else $error("result not one below lower minus delta");

    property p_band_hold;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (zone_d == window_cmp_pkg::ZONE_BAND) |=> $stable(o_result);
    endproperty
    a_band_hold: assert property (p_band_hold)
        else $error("result changed inside a hysteresis band");

    property p_unsigned_top;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (enabled && operand_q[`WORD_W-1] && cfg_q.delta == 16'h0000
         && operand_q > cfg_q.lower_threshold && operand_q < cfg_q.upper_threshold)
        |=> !o_result;
    endproperty
    a_unsigned_top: assert property (p_unsigned_top)
        else $error("top operand bit treated as a sign");

    property p_counter_operand;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (ctrl_q.src == window_cmp_pkg::SRC_COUNTER) |=> (operand_q == $past(i_count_word));
    endproperty
    a_counter_operand: assert property (p_counter_operand)
        else $error("counter word not taken as operand");

    property p_first_stage;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        ctrl_q.first_stage |=> (o_action_bit == o_result)
                               && (o_channel_out == $past(fb_image_q[`FB_CHAN_BIT]));
    endproperty
    a_first_stage: assert property (p_first_stage)
        else $error("first stage result not on action bit");

    property p_dedicated;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (ctrl_q.chan_dedicated && !ctrl_q.first_stage) |=> (o_channel_out == o_result);
    endproperty
    a_dedicated: assert property (p_dedicated)
        else $error("dedicated channel not driven by result");

    sequence s_disabled_run;
        !enabled [*3];
    endsequence
    property p_frozen;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        s_disabled_run |=> $stable(o_result);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("result moved while disabled");

    sequence s_reenable;
        !enabled ##1 (enabled && go_high);
    endsequence
    property p_reenable;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        s_reenable |=> o_result;
    endproperty
    a_reenable: assert property (p_reenable)
        else $error("latest inputs not acted on at enable");

    property p_reset_clear;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        $fell(i_sys_rst) |-> !o_result && !o_channel_out && !o_action_bit;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("outputs not cleared by reset");

endmodule

// ### outside_window_compare_tb.sv
// Self-checking bench for the outside-window comparator.
// Assumes the island model above and the design's constants header.
`timescale 1ns/1ps
`include "window_cmp_consts.svh"

module outside_window_compare_tb;
    logic        clk        = 1'b0;
    logic        rst        = 1'b1;
    logic [7:0]  addr       = 8'h00;
    logic [31:0] wdata      = 32'h0000_0000;
    logic        wr         = 1'b0;
    logic        rd         = 1'b0;
    logic [15:0] s1_word    = 16'h0000;
    logic [15:0] cnt_word   = 16'h0000;
    logic [15:0] isl_src    = 16'h0000;
    logic        en_src     = 1'b0;
    logic [15:0] isl_word;
    logic        en_pin;
    logic [31:0] rdata;
    logic        result;
    logic        chan;
    logic        act;
    int          failures   = 0;
    int          num_checks = 0;

    always #50 clk = ~clk;

    island_io_model u_isl (.i_clk_sys(clk), .i_word(isl_src), .i_level(en_src),
        .o_island_word(isl_word), .o_enable_pin(en_pin));

    outside_window_compare u_dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_addr(addr),
        .i_wr_data(wdata), .i_wr_stb(wr), .i_rd_stb(rd), .i_island_word(isl_word),
        .i_enable_pin(en_pin), .i_stage1_word(s1_word), .i_count_word(cnt_word),
        .o_rd_data(rdata), .o_result(result), .o_channel_out(chan), .o_action_bit(act));

    // ======================================================================
    // Shared bus and compare tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= {16'h0000, d};
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // Read data stand for one cycle only, so the cycle after is checked for zero.
    task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        chk(rdata, {16'h0000, e});
        @(negedge clk);
        chk(rdata, 32'h0000_0000);
    endtask

    // Island words cross two extra flops, so six cycles covers every source.
    task automatic settle();
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic step(input logic [15:0] x, input logic e);
        @(posedge clk);
        cnt_word <= x;
        settle();
        chk(result, e);
    endtask

    task automatic cfg(input logic [15:0] l, input logic [15:0] u, input logic [15:0] d);
        wr_reg(`OFS_LOWER_TH, l);
        wr_reg(`OFS_UPPER_TH, u);
        wr_reg(`OFS_DELTA, d);
        wr_reg(`OFS_CTRL, 16'h000d);
    endtask

    // ======================================================================
    // Scenarios
    task automatic test_reset();
        rd_reg(`OFS_CTRL, 16'h0000);
        rd_reg(`OFS_LOWER_TH, 16'h0000);
        rd_reg(`OFS_UPPER_TH, 16'hffff);
        rd_reg(`OFS_DELTA, 16'h0000);
        rd_reg(8'h20, 16'h0000);
        chk(result, 1'b0);
        $display("test reset done");
    endtask

    task automatic test_window();
        logic [15:0] zx[6] = '{16'h7d00, 16'h6d60, 16'h9c40, 16'h7531, 16'ha410, 16'h7530};
        logic        ze[6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
        logic [15:0] hx[10] = '{16'h4e20, 16'h7918, 16'h7d00, 16'h7d01, 16'ha40f,
                                16'ha410, 16'h9858, 16'h9470, 16'h6d60, 16'h6d5f};
        logic        he[10] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
        cfg(16'h7530, 16'h9c40, 16'h0000);
        foreach (zx[i]) step(zx[i], ze[i]);
        wr_reg(`OFS_DELTA, 16'h07d0);
        foreach (hx[i]) step(hx[i], he[i]);
        cfg(16'h0064, 16'h9000, 16'h0000);
        step(16'h8000, 1'b0);
        step(16'hffff, 1'b1);
        $display("test window done");
    endtask

    task automatic test_sources();
        cfg(16'h7530, 16'h9c40, 16'h0000);
        @(posedge clk);
        isl_src  <= 16'h88b8;
        s1_word  <= 16'h2710;
        cnt_word <= 16'h88b8;
        wr_reg(`OFS_VM_WORD, 16'hc350);
        wr_reg(`OFS_CTRL, 16'h0005);
        settle();
        chk(result, 1'b1);
        wr_reg(`OFS_CTRL, 16'h0001);
        settle();
        chk(result, 1'b0);
        wr_reg(`OFS_CTRL, 16'h0009);
        settle();
        chk(result, 1'b1);
        wr_reg(`OFS_CTRL, 16'h000d);
        settle();
        chk(result, 1'b0);
        rd_reg(`OFS_OPERAND, 16'h88b8);
        $display("test sources done");
    endtask

    task automatic test_enable();
        wr_reg(`OFS_CTRL, 16'h000c);
        step(16'ha410, 1'b0);
        rd_reg(`OFS_OPERAND, 16'ha410);
        wr_reg(`OFS_CTRL, 16'h000e);
        step(16'ha410, 1'b0);
        @(posedge clk);
        en_src <= 1'b1;
        settle();
        chk(result, 1'b1);
        wr_reg(`OFS_CTRL, 16'h000f);
        step(16'h88b8, 1'b1);
        wr_reg(`OFS_FB_IMAGE, 16'h0001);
        settle();
        chk(result, 1'b0);
        $display("test enable done");
    endtask

    task automatic test_channel();
        wr_reg(`OFS_CTRL, 16'h002d);
        wr_reg(`OFS_FB_IMAGE, 16'h0003);
        settle();
        chk(chan, 1'b0);
        step(16'ha410, 1'b1);
        chk(chan, 1'b1);
        chk(act, 1'b0);
        rd_reg(`OFS_FB_IMAGE, 16'h0003);
        wr_reg(`OFS_CTRL, 16'h003d);
        wr_reg(`OFS_FB_IMAGE, 16'h0000);
        settle();
        chk(act, 1'b1);
        chk(chan, 1'b0);
        $display("test channel done");
    endtask

    task automatic test_bus();
        wr_reg(`OFS_CTRL, 16'h000d);
        wr_reg(`OFS_STATUS, 16'hffff);
        settle();
        rd_reg(`OFS_STATUS, 16'h000f);
        wr_reg(8'h20, 16'h1234);
        rd_reg(8'h20, 16'h0000);
        wr_reg(`OFS_DELTA, 16'h1388);
        step(16'h4e20, 1'b1);
        rd_reg(`OFS_STATUS, 16'h001d);
        $display("test bus done");
    endtask

    // ======================================================================
    // Verdict and run control
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        for (int i = 0; i < 20000; i++) @(posedge clk);
        failures++;
        $display("ERROR at %0t: run did not finish", $time);
        report_and_stop();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_window();
        test_sources();
        test_enable();
        test_channel();
        test_bus();
        report_and_stop();
    end
endmodule

// ### two_flop_sync.sv
// Two flip-flop synchroniser for pins that arrive from outside the clock.
// Assumes each bit is a slow level; a multi-bit word may be torn while moving.
`timescale 1ns/1ps

module two_flop_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_sys_rst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    logic [W-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            meta_q <= '0;
            o_sync <= '0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end

endmodule

// ### window_cmp_consts.svh
// Offsets, field positions, reset values and widths of the window comparator.
// Assumes it is included by bare name from the design files that need it.
`ifndef WINDOW_CMP_CONSTS_SVH
`define WINDOW_CMP_CONSTS_SVH

// ==========================================================================
// Register byte offsets
`define OFS_CTRL        8'h00
`define OFS_LOWER_TH    8'h04
`define OFS_UPPER_TH    8'h08
`define OFS_DELTA       8'h0c
`define OFS_VM_WORD     8'h10
`define OFS_FB_IMAGE    8'h14
`define OFS_STATUS      8'h18
`define OFS_OPERAND     8'h1c

// ==========================================================================
// Field layout
`define CTRL_W          6
`define WORD_W          16
`define FB_W            2
`define FB_ECHO_BIT     0
`define FB_CHAN_BIT     1
`define STATUS_W        5

// ==========================================================================
// Reset values
`define RST_CTRL        6'h00
`define RST_LOWER_TH    16'h0000
`define RST_UPPER_TH    16'hffff
`define RST_DELTA       16'h0000
`define RST_WORD        16'h0000
`define RST_FB          2'h0
`define RST_RD_DATA     32'h0000_0000

`endif

// ### window_cmp_pkg.sv
// Types shared by the window comparator and its helpers.
// Assumes the constants header supplies the widths used here.
`include "window_cmp_consts.svh"

package window_cmp_pkg;

    // ======================================================================
    // Enable source and operand source selections
    typedef enum logic [1:0] {
        EN_ALWAYS_OFF = 2'h0,
        EN_ALWAYS_ON  = 2'h1,
        EN_PIN        = 2'h2,
        EN_FIELDBUS   = 2'h3
    } en_mode_t;

    typedef enum logic [1:0] {
        SRC_ISLAND  = 2'h0,
        SRC_VIRTUAL = 2'h1,
        SRC_STAGE1  = 2'h2,
        SRC_COUNTER = 2'h3
    } src_sel_t;

    // Zone of the operand, Gray coded in the order inside, band, high, low.
    typedef enum logic [1:0] {
        ZONE_INSIDE = 2'h0,
        ZONE_BAND   = 2'h1,
        ZONE_HIGH   = 2'h3,
        ZONE_LOW    = 2'h2
    } zone_t;

    // ======================================================================
    // Packed carriers
    typedef struct packed {
        logic     chan_dedicated;
        logic     first_stage;
        src_sel_t src;
        en_mode_t en_mode;
    } ctrl_t;

    typedef struct packed {
        logic [`WORD_W-1:0] lower_threshold;
        logic [`WORD_W-1:0] upper_threshold;
        logic [`WORD_W-1:0] delta;
    } cfg_t;

endpackage

// ### window_judge.sv
// Combinational window decision: which way the result must go for an operand.
// Assumes the thresholds and delta come from registers on the same clock.
`timescale 1ns/1ps
`include "window_cmp_consts.svh"

module window_judge (
    input  wire logic                  [`WORD_W-1:0] i_operand,
    input  wire window_cmp_pkg::cfg_t                i_cfg,
    output logic                                     o_go_high,
    output logic                                     o_go_low,
    output window_cmp_pkg::zone_t                    o_zone
);

    // Seventeen bits keep the sums from wrapping, so no bound ever turns round.
    logic [`WORD_W:0] op_plus_d;
    logic [`WORD_W:0] lo_plus_d;
    logic [`WORD_W:0] hi_plus_d;

    always_comb begin
        op_plus_d = {1'b0, i_operand} + {1'b0, i_cfg.delta};
        lo_plus_d = {1'b0, i_cfg.lower_threshold} + {1'b0, i_cfg.delta};
        hi_plus_d = {1'b0, i_cfg.upper_threshold} + {1'b0, i_cfg.delta};
        o_go_high = (op_plus_d < {1'b0, i_cfg.lower_threshold})
                  | ({1'b0, i_operand} >= hi_plus_d);
        o_go_low  = ({1'b0, i_operand} > lo_plus_d)
                  & (op_plus_d <= {1'b0, i_cfg.upper_threshold});
        if (o_go_high && ({1'b0, i_operand} >= hi_plus_d)) begin
            o_zone = window_cmp_pkg::ZONE_HIGH;
        end else if (o_go_high) begin
            o_zone = window_cmp_pkg::ZONE_LOW;
        end else if (o_go_low) begin
            o_zone = window_cmp_pkg::ZONE_INSIDE;
        end else begin
            o_zone = window_cmp_pkg::ZONE_BAND;
        end
    end

endmodule
